// file: rtl/boot_size_decode.sv
// boot-size fuse decoder for one flash size
module boot_size_decode
    import flash_map_pkg::*;
#(
    parameter logic [16:0] TOP = SMALL_TOP
) (
    input  wire logic        boot_size_sel_hi_in,
    input  wire logic        boot_size_sel_lo_in,
    output logic      [16:0] boot_start_out,
    output logic      [16:0] app_end_out,
    output logic      [16:0] boot_words_out
);
    always_comb
    begin
        unique case ({boot_size_sel_hi_in, boot_size_sel_lo_in}) // [RULE_01] [RULE_02]
            2'b11:   boot_words_out = BOOT_512_WORDS;
            2'b10:   boot_words_out = BOOT_1024_WORDS;
            2'b01:   boot_words_out = BOOT_2048_WORDS;
            default: boot_words_out = BOOT_4096_WORDS;
        endcase
        boot_start_out = TOP - boot_words_out + 17'h00001; // [RULE_02]
        app_end_out    = boot_start_out - 17'h00001;       // [RULE_02]
    end
endmodule : boot_size_decode

// file: rtl/flash_map_pkg.sv
// constants for the self-programming flash address map
// Functional notes
// RULE_01: small variant decodes boot-size fuses to 512..4096 word sections ending at top.
// RULE_02: large variant boot starts 0x1FE00..0x1F000; vector is start, application ends below.
// RULE_03: small variant concurrent area 0x0000-0xEFFF, stall area 0xF000-0xFFFF.
// RULE_04: large variant concurrent area 0x00000-0x1EFFF, stall area 0x1F000-0x1FFFF.
// RULE_05: program counter is 16 bits small, 17 bits large, addressing 16-bit words.
// RULE_06: pages hold 128 words; word index comes from pointer bits 7 to 1.
// RULE_07: page number from pointer bits 16..8 small, 17..8 large, for erase and write.
// RULE_08: CPU keeps word index bits zero through a page write.
// RULE_09: pointer bit 0 zero for stores; for loads it selects low or high byte.
// RULE_10: pointer is 16 bits; bits 16 and 17 come from the extension register.
// RULE_11: while the busy flag is set, accesses to the concurrent area are blocked.
// RULE_12: page write or erase to the stall area halts the CPU for the whole operation.
// RULE_13: flag address as boot when at or above boot start, stall area above limit; code flags the stall area at or above LIMIT.
package flash_map_pkg;
    localparam int          WORD_IDX_BITS    = 7;
    localparam int          PAGE_WORDS       = 128;
    localparam logic [16:0] SMALL_TOP        = 17'h0FFFF;
    localparam logic [16:0] LARGE_TOP        = 17'h1FFFF;
    localparam logic [16:0] BOOT_512_WORDS   = 17'h00200;
    localparam logic [16:0] BOOT_1024_WORDS  = 17'h00400;
    localparam logic [16:0] BOOT_2048_WORDS  = 17'h00800;
    localparam logic [16:0] BOOT_4096_WORDS  = 17'h01000;
    localparam logic [16:0] STALL_AREA_WORDS = 17'h01000;
    localparam logic [16:0] RESET_ADDR       = 17'h00000;
    typedef enum logic [1:0] {
        OP_IDLE,
        OP_FILL,
        OP_ERASE,
        OP_WRITE
    } op_t;
endpackage : flash_map_pkg

// file: rtl/self_prog_flash_address_map.sv
// flash address map for self-programming: sections, page and word split
module self_prog_flash_address_map
    import flash_map_pkg::*;
#(
    parameter bit LARGE = 1'b0
) (
    input  wire logic        sys_clk_in,
    input  wire logic        srst_in,
    input  wire logic        boot_size_sel_hi_in,
    input  wire logic        boot_size_sel_lo_in,
    input  wire logic [15:0] pointer_in,
    input  wire logic [7:0]  pointer_extension_reg_in,
    input  wire logic        store_req_in,
    input  wire logic [1:0]  store_kind_in,
    input  wire logic        program_load_instr_in,
    input  wire logic        op_done_in,
    input  wire logic        concurrent_area_busy_flag_in,
    input  wire logic [16:0] fetch_addr_in,
    output logic      [16:0] boot_start_out,
    output logic      [16:0] boot_reset_vector_out,
    output logic      [16:0] app_end_out,
    output logic      [9:0]  page_number_out,
    output logic      [6:0]  word_in_page_out,
    output logic      [16:0] load_word_addr_out,
    output logic             load_high_byte_out,
    output logic             fetch_is_boot_out,
    output logic             fetch_in_stall_area_out,
    output logic             fetch_blocked_out,
    output logic             cpu_halt_out,
    output logic             store_addr_error_out,
    output logic      [1:0]  op_out
);
    import flash_map_pkg::*;

    localparam int          PC_BITS = LARGE ? 17 : 16; // [RULE_05]
    localparam logic [16:0] TOP     = LARGE ? LARGE_TOP : SMALL_TOP;
    localparam logic [16:0] LIMIT   = TOP - STALL_AREA_WORDS + 17'h00001;

    logic [16:0] boot_start;
    logic [16:0] app_end;
    logic [17:0] full_ptr;
    logic [16:0] word_addr;
    logic [9:0]  page_d;
    logic [9:0]  page_q;
    logic [6:0]  word_d;
    logic [6:0]  word_q;
    logic [16:0] load_d;
    logic [16:0] load_q;
    logic        hb_d;
    logic        hb_q;
    logic        halt_d;
    logic        halt_q;
    logic        err_d;
    logic        err_q;
    op_t         op_d;
    op_t         op_q;

    boot_size_decode #(
        .TOP (TOP)
    ) u_decode (
        .boot_size_sel_hi_in (boot_size_sel_hi_in),
        .boot_size_sel_lo_in (boot_size_sel_lo_in),
        .boot_start_out      (boot_start),
        .app_end_out         (app_end),
        .boot_words_out      ()
    );

    // bits above the pointer come from the extension register
    assign full_ptr  = {pointer_extension_reg_in[1:0], pointer_in}; // [RULE_10]
    assign word_addr = LARGE ? full_ptr[17:1] : {1'b0, full_ptr[16:1]}; // [RULE_05]

    always_comb
    begin
        page_d = page_q;
        word_d = word_q;
        load_d = load_q;
        hb_d   = hb_q;
        halt_d = halt_q;
        err_d  = 1'b0;
        op_d   = op_q;
        if (program_load_instr_in)
        begin
            load_d = word_addr;
            hb_d   = pointer_in[0]; // [RULE_09]
        end
        unique case (op_q)
            OP_IDLE:
            begin
                if (store_req_in)
                begin
                    // a store with bit 0 set is still carried out, only flagged
                    err_d = pointer_in[0]; // [RULE_09]
                    unique case (store_kind_in)
                        2'd0:
                        begin
                            word_d = pointer_in[7:1]; // [RULE_06]
                            op_d   = OP_FILL;
                        end
                        2'd1:
                        begin
                            page_d = LARGE ? full_ptr[17:8] : {1'b0, full_ptr[16:8]}; // [RULE_07]
                            op_d   = OP_ERASE;
                            halt_d = word_addr >= LIMIT; // [RULE_12]
                        end
                        default:
                        begin
                            page_d = LARGE ? full_ptr[17:8] : {1'b0, full_ptr[16:8]}; // [RULE_07]
                            // word index must be zero for a page write
                            err_d  = pointer_in[0] | (pointer_in[7:1] != 7'h00); // [RULE_08]
                            op_d   = OP_WRITE;
                            halt_d = word_addr >= LIMIT; // [RULE_12]
                        end
                    endcase
                end
            end
            OP_FILL:
                op_d = OP_IDLE;
            OP_ERASE, OP_WRITE:
            begin
                if (op_done_in)
                begin
                    op_d   = OP_IDLE;
                    halt_d = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            page_q <= 10'h000;
            word_q <= 7'h00;
            load_q <= RESET_ADDR;
            hb_q   <= 1'b0;
            halt_q <= 1'b0;
            err_q  <= 1'b0;
            op_q   <= OP_IDLE;
        end
        else
        begin
            page_q <= page_d;
            word_q <= word_d;
            load_q <= load_d;
            hb_q   <= hb_d;
            halt_q <= halt_d;
            err_q  <= err_d;
            op_q   <= op_d;
        end
    end

    assign boot_start_out          = boot_start;
    assign boot_reset_vector_out   = boot_start; // [RULE_02]
    assign app_end_out             = app_end;
    assign page_number_out         = page_q;
    assign word_in_page_out        = word_q;
    assign load_word_addr_out      = load_q;
    assign load_high_byte_out      = hb_q;
    assign fetch_is_boot_out       = fetch_addr_in >= boot_start; // [RULE_13]
    assign fetch_in_stall_area_out = fetch_addr_in >= LIMIT; // [RULE_03] [RULE_04] [RULE_13]
    assign fetch_blocked_out       = concurrent_area_busy_flag_in & (fetch_addr_in < LIMIT); // [RULE_11]
    assign cpu_halt_out            = halt_q;
    assign store_addr_error_out    = err_q;
    assign op_out                  = op_q;

    stall_halt_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (op_q == OP_IDLE && store_req_in && store_kind_in != 2'd0 && word_addr >= LIMIT)
        |=> cpu_halt_out) else $error("halt missing for stall area op"); // [RULE_12]
    halt_hold_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (cpu_halt_out && !op_done_in) |=> cpu_halt_out) else $error("halt dropped early"); // [RULE_12]
    block_area_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (concurrent_area_busy_flag_in && fetch_addr_in <= LIMIT - 17'h00001)
        |-> fetch_blocked_out) else $error("busy area not blocked"); // [RULE_11]
    fill_word_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (op_q == OP_IDLE && store_req_in && store_kind_in == 2'd0)
        |=> word_in_page_out == $past(pointer_in[7:1])) else $error("bad word index"); // [RULE_06]
    erase_page_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (op_q == OP_IDLE && store_req_in && store_kind_in == 2'd1)
        |=> page_number_out[7:0] == $past(pointer_in[15:8])) else $error("bad page number"); // [RULE_07]
    load_byte_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        program_load_instr_in |=> load_high_byte_out == $past(pointer_in[0]))
        else $error("bad byte select"); // [RULE_09]
    vector_end_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        app_end_out + 17'h00001 == boot_reset_vector_out) else $error("vector mismatch"); // [RULE_02]
    boot_flag_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (fetch_addr_in == TOP) |-> (fetch_is_boot_out && fetch_in_stall_area_out))
        else $error("top word not boot"); // [RULE_13]
    boot_min_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        boot_start_out >= LIMIT) else $error("boot start below stall area"); // [RULE_01]
    // the next three checks tie registered results to the pointer seen at the taking edge
    write_page_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (op_q == OP_IDLE && store_req_in && store_kind_in[1])
        |=> page_number_out[7:0] == $past(pointer_in[15:8])) else $error("bad write page"); // [RULE_07]
    load_addr_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        program_load_instr_in |=> load_word_addr_out[14:0] == $past(pointer_in[15:1]))
        else $error("bad load word address"); // [RULE_05]
    load_ext_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        program_load_instr_in |=> load_word_addr_out[15] == $past(pointer_extension_reg_in[0]))
        else $error("extension bit not used"); // [RULE_10]
    halt_end_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (cpu_halt_out && op_done_in) |=> !cpu_halt_out) else $error("halt not released"); // [RULE_12]
    no_halt_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (op_q == OP_IDLE && store_req_in && word_addr < LIMIT)
        |=> !cpu_halt_out) else $error("halt in concurrent area"); // [RULE_12]
    store_error_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (op_q == OP_IDLE && store_req_in && pointer_in[0])
        |=> store_addr_error_out) else $error("odd pointer not flagged"); // [RULE_09]
    fill_idle_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (op_q == OP_FILL) |=> (op_q == OP_IDLE)) else $error("fill not single cycle"); // [RULE_06]
    stall_flag_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        fetch_in_stall_area_out == (fetch_addr_in >= TOP - 17'h00FFF))
        else $error("stall flag wrong"); // [RULE_03]
    idle_error_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (!store_req_in) |=> !store_addr_error_out) else $error("error without store"); // [RULE_09]
endmodule : self_prog_flash_address_map

// file: testbench/flash_op_partner.sv
// flash timing partner: ends erase and write, reports concurrent-area busy
module flash_op_partner (
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    input  wire logic [1:0] op_in,
    input  wire logic       halt_in,
    input  wire logic       slow_in,
    output logic            done_out = 1'b0,
    output logic            busy_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    // busy only while an erase or write runs outside the stall area
    assign busy_out = op_in[1] && !halt_in;
    always @(posedge clk_in)
    begin
        done_out <= 1'b0;
        if (srst_in || !op_in[1])
            cnt <= 0;
        else if (cnt == (slow_in ? 12 : 2))
        begin
            done_out <= 1'b1;
            cnt      <= 0;
        end
        else
            cnt <= cnt + 1;
    end
endmodule : flash_op_partner

// file: testbench/self_prog_flash_address_map_tb.sv
// bench for the self-programming flash address map, large variant with a small variant alongside
module self_prog_flash_address_map_tb;
    import flash_map_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_in = 0, srst_in = 1, boot_size_sel_hi_in = 1, boot_size_sel_lo_in = 1, slow = 0;
    logic store_req_in = 0, program_load_instr_in = 0, op_done_in, concurrent_area_busy_flag_in;
    logic [15:0] pointer_in = 16'h0000;
    logic [7:0]  pointer_extension_reg_in = 8'h00;
    logic [1:0]  store_kind_in = 2'h0, op_out;
    logic [16:0] fetch_addr_in = 17'h00000, boot_start_out, boot_reset_vector_out, app_end_out;
    logic [16:0] load_word_addr_out;
    logic [9:0]  page_number_out;
    logic [6:0]  word_in_page_out;
    logic load_high_byte_out, fetch_is_boot_out, fetch_in_stall_area_out, fetch_blocked_out;
    logic cpu_halt_out, store_addr_error_out;
    // small variant sees the same stimulus; only its boot start, stall flag, page number and load address are compared
    logic [16:0] boot_start_small, load_small;
    logic [9:0]  page_small;
    logic        stall_small;
    logic [31:0] rng = 32'h11;
    int err_count = 0, samples_checked = 0;
    always #20 sys_clk_in = ~sys_clk_in;
    self_prog_flash_address_map #(.LARGE(1'b1)) DUT (.sys_clk_in, .srst_in, .boot_size_sel_hi_in,
        .boot_size_sel_lo_in, .pointer_in, .pointer_extension_reg_in, .store_req_in, .store_kind_in,
        .program_load_instr_in, .op_done_in, .concurrent_area_busy_flag_in, .fetch_addr_in,
        .boot_start_out, .boot_reset_vector_out, .app_end_out, .page_number_out, .word_in_page_out,
        .load_word_addr_out, .load_high_byte_out, .fetch_is_boot_out, .fetch_in_stall_area_out,
        .fetch_blocked_out, .cpu_halt_out, .store_addr_error_out, .op_out);
    self_prog_flash_address_map #(.LARGE(1'b0)) dut_small (.sys_clk_in, .srst_in,
        .boot_size_sel_hi_in, .boot_size_sel_lo_in, .pointer_in, .pointer_extension_reg_in,
        .store_req_in, .store_kind_in, .program_load_instr_in, .op_done_in,
        .concurrent_area_busy_flag_in, .fetch_addr_in, .boot_start_out(boot_start_small),
        .boot_reset_vector_out(), .app_end_out(), .page_number_out(page_small),
        .word_in_page_out(), .load_word_addr_out(load_small), .load_high_byte_out(),
        .fetch_is_boot_out(), .fetch_in_stall_area_out(stall_small), .fetch_blocked_out(),
        .cpu_halt_out(), .store_addr_error_out(), .op_out());
    flash_op_partner partner (.clk_in(sys_clk_in), .srst_in, .op_in(op_out), .halt_in(cpu_halt_out),
        .slow_in(slow), .done_out(op_done_in), .busy_out(concurrent_area_busy_flag_in));
    task automatic end_of_test();
        $display("checked %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input bit good, input string what);
        samples_checked++;
        if (!good)
        begin
            err_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : chk
    // integer model of the fuse decode and the fetch flags
    task automatic check_map();
        int s = 32'h20000 - (32'h200 << (3 - {boot_size_sel_hi_in, boot_size_sel_lo_in}));
        int a = fetch_addr_in;
        int t = 32'h10000 - (32'h200 << (3 - {boot_size_sel_hi_in, boot_size_sel_lo_in}));
        chk(boot_start_small === 17'(t), "small boot start");
        chk(stall_small === (a >= 32'hF000), "small stall flag");
        chk(boot_start_out === 17'(s) && boot_reset_vector_out === 17'(s), "boot start");
        chk(app_end_out === 17'(s - 1), "app end");
        chk(fetch_is_boot_out === (a >= s), "boot flag");
        chk(fetch_in_stall_area_out === (a >= 32'h1F000), "stall flag");
        chk(fetch_blocked_out === (concurrent_area_busy_flag_in && a < 32'h1F000), "block");
    endtask : check_map
    task automatic store(input logic [1:0] k, input logic [15:0] p, input logic [7:0] e);
        int w = {e[1:0], p} >> 1;
        int n = 0;
        pointer_in = p;
        pointer_extension_reg_in = e;
        store_kind_in = k;
        store_req_in = 1;
        @(posedge sys_clk_in);
        #1 store_req_in = 0;
        chk(op_out === (k[1] ? 2'h3 : k + 2'h1), "op kind");
        chk(store_addr_error_out === (p[0] || (k[1] && w[6:0] != 0)), "addr error");
        if (k == 2'h0)
            chk(word_in_page_out === w[6:0], "word index");
        else
            chk(page_number_out === w[16:7] && cpu_halt_out === (w >= 32'h1F000), "page");
        if (k != 2'h0)
            chk(page_small === {1'b0, w[15:7]}, "small page");
        while (op_out !== 2'h0 && n++ < 40)
        begin
            @(posedge sys_clk_in);
            #1 check_map();
        end
        chk(op_out === 2'h0 && cpu_halt_out === 1'b0, "op end");
    endtask : store
    task automatic load(input logic [15:0] p, input logic [7:0] e);
        pointer_in = p;
        pointer_extension_reg_in = e;
        program_load_instr_in = 1;
        @(posedge sys_clk_in);
        #1 program_load_instr_in = 0;
        chk(load_word_addr_out === 17'({e[1:0], p} >> 1) && load_high_byte_out === p[0], "load");
        chk(load_small === 17'({e[0], p} >> 1), "small load");
    endtask : load
    initial
    begin
        #200000 err_count++;
        end_of_test();
    end
    initial
    begin
        logic [15:0] p;
        logic [7:0]  e;
        repeat (12) @(posedge sys_clk_in);
        #1 srst_in = 0;
        for (int i = 0; i < 64; i++)
        begin
            rng ^= rng << 13;
            rng ^= rng >> 17;
            rng ^= rng << 5;
            {boot_size_sel_hi_in, boot_size_sel_lo_in} = rng[1:0];
            slow = rng[2];
            fetch_addr_in = (i % 3 == 0) ? 17'h1EFFF + 17'(i[1]) : rng[31:15];
            p = rng[20:5];
            e = rng[28:21];
            if (i[0])
            begin
                p[15:13] = 3'h7;
                e[1:0] = 2'h3;
            end
            if (rng[4] && i % 8 != 7)
                p[7:1] = 7'h00;
            if (i % 8 != 5)
                p[0] = 1'b0;
            @(posedge sys_clk_in);
            #1 check_map();
            store(rng[4:3], p, e);
            load(rng[31:16], e);
        end
        end_of_test();
    end
endmodule : self_prog_flash_address_map_tb
